// ===== pcs_pfd.sv
// Phase and frequency comparison of reference and feedback divider outputs with antibacklash overlap
`timescale 1ns/1ps
`default_nettype none
module pcs_pfd (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic [1:0] abl,
    input wire logic ref_div,
    input wire logic fb_div,
    output logic up,
    output logic dn
);
    logic ref_q;
    logic fb_q;
    logic [1:0] overlap_cnt;
    logic ref_edge;
    logic fb_edge;

    assign ref_edge = ref_div & ~ref_q;
    assign fb_edge = fb_div & ~fb_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 1'b0;
            fb_q <= 1'b0;
        end else if (clk_en) begin
            ref_q <= ref_div;
            fb_q <= fb_div;
        end
    end

    // Both outputs stay high together for abl+1 cycles so there is no dead zone
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up <= 1'b0;
            dn <= 1'b0;
            overlap_cnt <= 2'h0;
        end else if (clk_en) begin
            if (!enable) begin
                up <= 1'b0;
                dn <= 1'b0;
                overlap_cnt <= 2'h0;
            end else if (up && dn) begin
                if (overlap_cnt == abl) begin
                    up <= 1'b0;
                    dn <= 1'b0;
                    overlap_cnt <= 2'h0;
                end else begin
                    overlap_cnt <= overlap_cnt + 2'h1;
                end
            end else begin
                if (ref_edge) begin
                    up <= 1'b1;
                end
                if (fb_edge) begin
                    dn <= 1'b1;
                end
            end
        end
    end
endmodule // pcs_pfd
`default_nettype wire

// ===== pcs_pkg.sv
// Package with register map, field layout, encodings and types of the PLL clock source control block
package pcs_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int PCS_ADDR_W = 12;
    localparam logic [9:0] PCS_IDX_PLL_CTRL = 10'h010;
    localparam logic [9:0] PCS_IDX_PUMP_CUR = 10'h020;
    localparam logic [9:0] PCS_IDX_ABL = 10'h017;
    localparam logic [9:0] PCS_IDX_CAL = 10'h018;
    localparam logic [9:0] PCS_IDX_DIV = 10'h1e0;
    localparam logic [9:0] PCS_IDX_SRC = 10'h1e1;
    localparam logic [9:0] PCS_IDX_UPDATE = 10'h232;
    localparam logic [9:0] PCS_IDX_STATUS = 10'h240;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PCS_PWR_LSB = 0;
    localparam int PCS_PUMP_LSB = 4;
    localparam int PCS_POL_BIT = 7;
    localparam int PCS_CAL_BIT = 0;
    localparam int PCS_BYP_BIT = 0;
    localparam int PCS_SRC_BIT = 1;

    // ------------------------------------------------------------
    // Encodings and values after reset
    // ------------------------------------------------------------
    localparam logic [1:0] PCS_PWR_ON = 2'h0;
    localparam logic [1:0] PCS_PWR_DOWN = 2'h1;
    localparam logic [2:0] PCS_PUMP_HIZ = 3'h0;
    localparam logic [2:0] PCS_PUMP_FORCE_UP = 3'h1;
    localparam logic [2:0] PCS_PUMP_FORCE_DN = 3'h2;
    localparam logic [2:0] PCS_PUMP_NORMAL = 3'h3;
    localparam logic [2:0] PCS_DIV_RST = 3'h2;
    localparam logic [2:0] PCS_DIV_MAX_CODE = 3'h4;
    localparam logic [2:0] PCS_DIV_BASE = 3'h2;
    localparam logic [7:0] PCS_UPDATE_KEY = 8'h01;
    localparam logic [12:0] PCS_PUMP_LSB_UA = 13'h0258;
    localparam logic [1:0] PCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Configuration carried as one unit
    // ------------------------------------------------------------
    typedef struct packed {
        logic       pol_neg;
        logic [2:0] pump_mode;
        logic [1:0] pwr;
        logic [2:0] cur_step;
        logic [1:0] abl;
        logic       cal;
        logic [2:0] div_code;
        logic       bypass;
        logic       src_int;
    } pcs_cfg_t;

    localparam pcs_cfg_t PCS_CFG_RST = '{pol_neg: 1'b0, pump_mode: PCS_PUMP_HIZ, pwr: PCS_PWR_DOWN,
        cur_step: 3'h0, abl: 2'h0, cal: 1'b0, div_code: PCS_DIV_RST, bypass: 1'b0, src_int: 1'b0};

endpackage

// ===== pcs_pll_clock_source.sv
// PLL clock source control: AXI4-Lite registers, staged commit, source routing and charge pump drive
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcs_pll_clock_source (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [pcs_pkg::PCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcs_pkg::PCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_div,
    input wire logic fb_div,
    output pcs_pkg::pcs_cfg_t active_cfg,
    output logic pll_powered_down,
    output logic src_internal,
    output logic div_bypass,
    output logic [2:0] div_ratio,
    output logic charge_pump_up,
    output logic charge_pump_dn,
    output logic charge_pump_hiz,
    output logic [12:0] charge_pump_ua,
    output logic cal_start
);
    import pcs_pkg::*;

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    pcs_cfg_t staged_cfg;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [9:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic wr_fire;
    logic commit;
    logic update_pending;
    logic pfd_up;
    logic pfd_dn;
    logic pll_on;
    logic [9:0] rd_idx;

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == PCS_IDX_PLL_CTRL) || (idx == PCS_IDX_PUMP_CUR) || (idx == PCS_IDX_ABL)
            || (idx == PCS_IDX_CAL) || (idx == PCS_IDX_DIV) || (idx == PCS_IDX_SRC)
            || (idx == PCS_IDX_UPDATE) || (idx == PCS_IDX_STATUS);
    endfunction

    function automatic logic [2:0] div_decode(input logic [2:0] code);
        // Codes above the largest legal one fall back to the deepest divide
        if (code > PCS_DIV_MAX_CODE) begin
            div_decode = PCS_DIV_BASE + PCS_DIV_MAX_CODE;
        end else begin
            div_decode = PCS_DIV_BASE + code;
        end
    endfunction

    // Ready drops while frozen so no beat is taken that state cannot record
    assign s_axi_awready = clk_en & ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = clk_en & ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    assign wr_idx = aw_held ? aw_idx : s_axi_awaddr[PCS_ADDR_W-1:2];
    assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
    assign wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
    assign wr_fire = clk_en & (aw_held | aw_take) & (w_held | w_take);
    assign rd_idx = s_axi_araddr[PCS_ADDR_W-1:2];
    assign commit = wr_fire & wr_lane0 & (wr_idx == PCS_IDX_UPDATE) & (wr_byte == PCS_UPDATE_KEY);

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h000;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCS_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= idx_mapped(wr_idx) ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_idx <= s_axi_awaddr[PCS_ADDR_W-1:2];
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_byte <= s_axi_wdata[7:0];
                    w_lane0 <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------
    // writes land in staging
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            staged_cfg <= PCS_CFG_RST;
        end else if (clk_en && wr_fire && wr_lane0) begin
            case (wr_idx)
                PCS_IDX_PLL_CTRL: begin
                    staged_cfg.pwr <= wr_byte[PCS_PWR_LSB+:2];
                    staged_cfg.pump_mode <= wr_byte[PCS_PUMP_LSB+:3];
                    staged_cfg.pol_neg <= wr_byte[PCS_POL_BIT];
                end
                PCS_IDX_PUMP_CUR: staged_cfg.cur_step <= wr_byte[2:0];
                PCS_IDX_ABL: staged_cfg.abl <= wr_byte[1:0];
                PCS_IDX_CAL: staged_cfg.cal <= wr_byte[PCS_CAL_BIT];
                PCS_IDX_DIV: staged_cfg.div_code <= wr_byte[2:0];
                PCS_IDX_SRC: begin
                    staged_cfg.bypass <= wr_byte[PCS_BYP_BIT];
                    staged_cfg.src_int <= wr_byte[PCS_SRC_BIT];
                end
                default: staged_cfg <= staged_cfg;
            endcase
        end
    end

    // Pending marks staged values not yet committed; a write and an update never share a cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            update_pending <= 1'b0;
        end else if (clk_en && wr_fire && wr_lane0) begin
            if (commit) begin
                update_pending <= 1'b0;
            end else if (idx_mapped(wr_idx) && wr_idx != PCS_IDX_STATUS && wr_idx != PCS_IDX_UPDATE) begin
                update_pending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Active registers and calibration start
    // ------------------------------------------------------------
    // single-step copy to active
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_cfg <= PCS_CFG_RST;
        end else if (clk_en && commit) begin
            active_cfg <= staged_cfg;
        end
    end

    // start only on a committed 0 to 1
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_start <= 1'b0;
        end else if (clk_en) begin
            cal_start <= commit & staged_cfg.cal & ~active_cfg.cal;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PCS_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= idx_mapped(rd_idx) ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
                case (rd_idx)
                    PCS_IDX_PLL_CTRL: s_axi_rdata <= {24'h000000, staged_cfg.pol_neg, staged_cfg.pump_mode,
                        2'h0, staged_cfg.pwr};
                    PCS_IDX_PUMP_CUR: s_axi_rdata <= {29'h00000000, staged_cfg.cur_step};
                    PCS_IDX_ABL: s_axi_rdata <= {30'h00000000, staged_cfg.abl};
                    PCS_IDX_CAL: s_axi_rdata <= {31'h00000000, staged_cfg.cal};
                    PCS_IDX_DIV: s_axi_rdata <= {29'h00000000, staged_cfg.div_code};
                    PCS_IDX_SRC: s_axi_rdata <= {30'h00000000, staged_cfg.src_int, staged_cfg.bypass};
                    PCS_IDX_STATUS: s_axi_rdata <= {26'h0000000, update_pending, charge_pump_hiz, charge_pump_dn,
                        charge_pump_up, active_cfg.src_int, pll_powered_down};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase detector and charge pump drive
    // ------------------------------------------------------------
    // only code 00 runs the loop
    assign pll_on = (active_cfg.pwr == PCS_PWR_ON);

    pcs_pfd u_phase_freq_detector (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(pll_on && active_cfg.pump_mode == PCS_PUMP_NORMAL),
        .abl(active_cfg.abl),
        .ref_div(ref_div),
        .fb_div(fb_div),
        .up(pfd_up),
        .dn(pfd_dn)
    );

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            charge_pump_up <= 1'b0;
            charge_pump_dn <= 1'b0;
            charge_pump_hiz <= 1'b1;
        end else if (clk_en) begin
            if (!pll_on) begin
                charge_pump_up <= 1'b0;
                charge_pump_dn <= 1'b0;
                charge_pump_hiz <= 1'b1;
            end else begin
                case (active_cfg.pump_mode)
                    PCS_PUMP_NORMAL: begin
                        charge_pump_up <= active_cfg.pol_neg ? pfd_dn : pfd_up;
                        charge_pump_dn <= active_cfg.pol_neg ? pfd_up : pfd_dn;
                        charge_pump_hiz <= 1'b0;
                    end
                    PCS_PUMP_FORCE_UP: begin
                        charge_pump_up <= 1'b1;
                        charge_pump_dn <= 1'b0;
                        charge_pump_hiz <= 1'b0;
                    end
                    PCS_PUMP_FORCE_DN: begin
                        charge_pump_up <= 1'b0;
                        charge_pump_dn <= 1'b1;
                        charge_pump_hiz <= 1'b0;
                    end
                    default: begin
                        charge_pump_up <= 1'b0;
                        charge_pump_dn <= 1'b0;
                        charge_pump_hiz <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Routing and pump current outputs
    // ------------------------------------------------------------
    // Source selection stays live even with the loop off, for pure distribution use
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_powered_down <= 1'b1;
            src_internal <= 1'b0;
            div_bypass <= 1'b0;
            div_ratio <= PCS_DIV_BASE + PCS_DIV_RST;
            charge_pump_ua <= PCS_PUMP_LSB_UA;
        end else if (clk_en) begin
            pll_powered_down <= ~pll_on;
            src_internal <= active_cfg.src_int;
            div_bypass <= active_cfg.bypass;
            div_ratio <= div_decode(active_cfg.div_code);
            charge_pump_ua <= PCS_PUMP_LSB_UA * ({10'h000, active_cfg.cur_step} + 13'h0001);
        end
    end
endmodule // pcs_pll_clock_source
`default_nettype wire

// ===== pcs_pll_clock_source_bench.sv
// Self-checking bench of the PLL clock source control block
`timescale 1ns/1ps
`default_nettype none
module pcs_pll_clock_source_bench;
    import pcs_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic run = 1'b0;
    logic [3:0] lag = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_div, fb_div;
    logic pll_powered_down, src_internal, div_bypass, charge_pump_up, charge_pump_dn, charge_pump_hiz, cal_start;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] div_ratio;
    logic [12:0] charge_pump_ua;
    pcs_cfg_t active_cfg;
    logic [7:0] mode_tab [4] = '{8'h10, 8'h20, 8'h00, 8'h11};
    logic [1:0] pump_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
    int err_total = 0;
    int n_tests = 0;
    int cal_cnt = 0;
    int cu, cd, cb;

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cal_start === 1'b1) cal_cnt++;

    pcs_pll_clock_source DUT (.sys_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ref_div, .fb_div, .active_cfg, .pll_powered_down, .src_internal, .div_bypass, .div_ratio,
        .charge_pump_up, .charge_pump_dn, .charge_pump_hiz, .charge_pump_ua, .cal_start);
    pcs_ref_model u_ref (.sys_clk, .run, .lag, .ref_div, .fb_div);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] resp = PCS_RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
        chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] resp = PCS_RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
    endtask

    task automatic commit();
        wr(PCS_IDX_UPDATE, PCS_UPDATE_KEY);
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic pfd(input logic [3:0] l);
        lag <= l;
        cu = 0;
        cd = 0;
        cb = 0;
        repeat (64) @(posedge sys_clk);
        repeat (32) begin
            @(posedge sys_clk);
            if (charge_pump_up === 1'b1 && charge_pump_dn === 1'b0) cu++;
            if (charge_pump_up === 1'b0 && charge_pump_dn === 1'b1) cd++;
            if (charge_pump_up === 1'b1 && charge_pump_dn === 1'b1) cb++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk("pd", 32'h1, {31'h0, pll_powered_down}); // default off
        chk("src", 32'h0, {31'h0, src_internal}); // default input
        chk("byp", 32'h0, {31'h0, div_bypass}); // default divider
        chk("ratio", 32'h4, {29'h0, div_ratio}); // default ratio
        chk("ua", 32'h258, {19'h0, charge_pump_ua}); // lowest step
        rd(PCS_IDX_PLL_CTRL, 32'h1); // power field
        rd(10'h3ff, 32'h0, PCS_RESP_SLVERR);
        wr(10'h3ff, 8'h5a, PCS_RESP_SLVERR);
        rd(PCS_IDX_UPDATE, 32'h0);
        $display("test reset and map done");
        wr(PCS_IDX_SRC, 8'h01); // bypass input
        wr(PCS_IDX_PLL_CTRL, 8'h01); // power down
        rd(PCS_IDX_STATUS, 32'h31); // pending, pump hiz, powered down
        rd(PCS_IDX_SRC, 32'h1); // staged value
        wr(PCS_IDX_UPDATE, 8'h02); // wrong key
        repeat (3) @(posedge sys_clk);
        chk("byp", 32'h0, {31'h0, div_bypass}); // not yet
        commit(); // commit
        chk("byp", 32'h1, {31'h0, div_bypass}); // bypassed
        chk("src", 32'h0, {31'h0, src_internal}); // input pair
        wr(PCS_IDX_SRC, 8'h03); // bypass kept
        wr(PCS_IDX_PLL_CTRL, 8'h00); // power on
        commit(); // commit
        chk("src", 32'h1, {31'h0, src_internal}); // oscillator
        chk("pd", 32'h0, {31'h0, pll_powered_down}); // running
        rd(PCS_IDX_STATUS, 32'h12); // pump idle
        $display("test staging done");
        for (int i = 0; i < 8; i++) begin
            wr(PCS_IDX_DIV, 8'(i)); // code
            wr(PCS_IDX_PUMP_CUR, 8'(i)); // step
            commit(); // commit
            chk("ratio", i > 4 ? 32'h6 : 32'(i + 2), {29'h0, div_ratio}); // ratio
            chk("ua", 32'h258 * 32'(i + 1), {19'h0, charge_pump_ua}); // current
        end
        $display("test divider and current done");
        for (int i = 0; i < 4; i++) begin
            wr(PCS_IDX_PLL_CTRL, mode_tab[i]); // mode
            commit(); // commit
            chk("pump", {30'h0, pump_tab[i]}, {30'h0, charge_pump_up, charge_pump_dn}); // drive
        end
        $display("test pump modes done");
        run <= 1'b1;
        wr(PCS_IDX_PLL_CTRL, 8'h30); // normal
        commit(); // commit
        pfd(4'h4);
        chk("up", 32'h4, 32'(cu)); // ref leads
        chk("dn", 32'h0, 32'(cd)); // no down
        wr(PCS_IDX_PLL_CTRL, 8'hb0); // negative
        commit(); // commit
        pfd(4'h4);
        chk("dn", 32'h4, 32'(cd)); // swapped
        chk("up", 32'h0, 32'(cu)); // swapped
        for (int a = 0; a < 4; a++) begin
            wr(PCS_IDX_ABL, 8'(a)); // width
            commit(); // commit
            pfd(4'h0);
            chk("overlap", 32'(a + 1), 32'(cb)); // width
        end
        clk_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("ready", 32'h0, {30'h0, s_axi_awready, s_axi_arready}); // frozen
        clk_en <= 1'b1;
        $display("test detector done");
        cu = cal_cnt;
        wr(PCS_IDX_CAL, 8'h01); // set bit
        commit(); // start
        chk("cal", 32'h1, 32'(cal_cnt - cu)); // one pulse
        wr(PCS_IDX_CAL, 8'h01); // still set
        commit(); // no repeat
        chk("cal", 32'h1, 32'(cal_cnt - cu)); // no pulse
        wr(PCS_IDX_CAL, 8'h00); // clear first
        commit(); // clear
        wr(PCS_IDX_CAL, 8'h01); // recalibrate
        commit(); // start
        chk("cal", 32'h2, 32'(cal_cnt - cu)); // second pulse
        $display("test calibration done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk("pd", 32'h1, {31'h0, pll_powered_down}); // off again
        rd(PCS_IDX_SRC, 32'h0); // staged cleared
        $display("test second reset done");
        results();
    end

    // Run needs about 800 cycles; the limit of 10000 cycles allows over ten times that
    initial begin
        #1000000;
        err_total++;
        results();
    end
endmodule // pcs_pll_clock_source_bench
`default_nettype wire

// ===== pcs_pll_clock_source_sva.sv
// Checker of routing, commit and pump drive at the block's ports
`timescale 1ns/1ps
`default_nettype none
module pcs_pll_clock_source_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic s_axi_bvalid,
    input wire pcs_pkg::pcs_cfg_t active_cfg,
    input wire logic pll_powered_down,
    input wire logic src_internal,
    input wire logic div_bypass,
    input wire logic [2:0] div_ratio,
    input wire logic charge_pump_up,
    input wire logic charge_pump_dn,
    input wire logic charge_pump_hiz,
    input wire logic [12:0] charge_pump_ua,
    input wire logic cal_start
);
    import pcs_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_PWR_OFF: assert property (active_cfg.pwr != PCS_PWR_ON |=> pll_powered_down) // off
        else $error("power flag low while field is off");
    AST_PWR_ON: assert property (active_cfg.pwr == PCS_PWR_ON |=> !pll_powered_down) // on
        else $error("power flag high while field is on");
    AST_BYPASS: assert property (1'b1 |=> div_bypass == $past(active_cfg.bypass)) // bypass
        else $error("bypass output differs from committed bit");
    AST_SOURCE: assert property (1'b1 |=> src_internal == $past(active_cfg.src_int)) // source
        else $error("source output differs from committed bit");
    AST_DIVIDE: assert property (1'b1 |=> div_ratio == ($past(active_cfg.div_code) > PCS_DIV_MAX_CODE ? // ratio
        3'h6 : $past(active_cfg.div_code) + PCS_DIV_BASE))
        else $error("divide ratio wrong for committed code");
    AST_CURRENT: assert property (1'b1 |=> charge_pump_ua == PCS_PUMP_LSB_UA * // current
        ({10'h0, $past(active_cfg.cur_step)} + 13'h1))
        else $error("pump current wrong for committed step");
    AST_IDLE: assert property ((active_cfg.pwr != PCS_PWR_ON)[*2] |=> !charge_pump_up && !charge_pump_dn) // idle
        else $error("pump driven while powered down");
    AST_HIZ: assert property ((active_cfg.pump_mode == PCS_PUMP_HIZ)[*2] |=> // hiz
        charge_pump_hiz && !charge_pump_up && !charge_pump_dn)
        else $error("pump not high impedance in that mode");
    AST_COMMIT: assert property ($changed(active_cfg) |-> $rose(s_axi_bvalid)) // commit
        else $error("active settings changed without a write answer");
    AST_CAL_GO: assert property ($rose(active_cfg.cal) |-> ##[0:1] cal_start) // start
        else $error("calibration start missing after commit");
    AST_CAL_ONE: assert property (cal_start |=> !cal_start) // pulse
        else $error("calibration start longer than one cycle");

    COV_CAL: cover property (cal_start);
    COV_UP: cover property (charge_pump_up && !charge_pump_dn);
    COV_BOTH: cover property (charge_pump_up && charge_pump_dn);
endmodule // pcs_pll_clock_source_sva

bind pcs_pll_clock_source pcs_pll_clock_source_sva u_sva (.sys_clk, .sys_rst, .s_axi_bvalid, .active_cfg,
    .pll_powered_down, .src_internal, .div_bypass, .div_ratio, .charge_pump_up, .charge_pump_dn,
    .charge_pump_hiz, .charge_pump_ua, .cal_start);
`default_nettype wire

// ===== pcs_ref_model.sv
// Stand-in for the reference and feedback divider outputs
`timescale 1ns/1ps
`default_nettype none
module pcs_ref_model (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [3:0] lag,
    output logic ref_div,
    output logic fb_div
);
    logic [4:0] phase = 5'h0;
    logic [4:0] fb_phase;

    assign fb_phase = phase - {1'b0, lag};

    // Period of 32 cycles; both lines rest low while stopped
    always_ff @(posedge sys_clk) begin
        phase <= run ? phase + 5'h1 : 5'h0;
    end

    always_ff @(posedge sys_clk) begin
        ref_div <= run && phase < 5'h8;
        fb_div <= run && fb_phase < 5'h8;
    end
endmodule // pcs_ref_model
`default_nettype wire
